// *** src/shp_pkg.sv ***
// Constants and types for the serial host register port
// Operation
// - Port works only while interface select is low; high hands pins to JTAG.
// - Four wires: serial in, serial out, active-low chip select, burst clock.
// - Command word is 16 bits, MSB first: read flag, step flag, 12-bit address.
// - Device samples command bits on the rising serial clock edge.
// - Read flag one selects a read, zero selects a write.
// - With address step each later data word goes to the next address.
// - Unused command bits may be zero; the device ignores them.
// - Read MSB appears on the first fall after the command's last rising edge, then one per fall.
// - Serial output is a combinational copy of serial input during writes.
// - Every chained device with chip select and interface select low stores the same write.
package shp_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 12;
  localparam int CNT_W = 4;
  // Command word field positions
  localparam int CMD_RW_BIT = 15;
  localparam int CMD_STEP_BIT = 12;
  localparam int CMD_ADDR_MSB = 11;
  localparam logic [CNT_W-1:0] LAST_BIT = 4'hF;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 12'h001;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 12'h000;
  // Host-side gap the device relies on, not timed by the device
  localparam real WRITE_GAP_NS = 37.1;
  // Synchronised pin lanes
  localparam int SYNC_W = 4;
  localparam int LANE_SCLK = 0;
  localparam int LANE_CSN = 1;
  localparam int LANE_HOST_SERIAL_IN = 2;
  localparam int LANE_JSEL = 3;
  // Gray codes along idle -> command -> data
  typedef enum logic [1:0] {
    SHP_IDLE = 2'b00,
    SHP_CMD = 2'b01,
    SHP_DATA = 2'b11
  } shp_state_t;
endpackage : shp_pkg

// *** src/shp_sync_if.sv ***
// Synchronised pin levels and edges passed between port modules
`timescale 1ns/100ps
interface shp_sync_if;
  logic [shp_pkg::SYNC_W-1:0] lvl;
  logic [shp_pkg::SYNC_W-1:0] rise;
  logic [shp_pkg::SYNC_W-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface : shp_sync_if

// *** src/shp_sync.sv ***
// Two-flop synchroniser with edge detection for the host pins
`timescale 1ns/100ps
module shp_sync (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [shp_pkg::SYNC_W-1:0] raw,
  shp_sync_if.src o
);
  logic [shp_pkg::SYNC_W-1:0] meta;
  logic [shp_pkg::SYNC_W-1:0] stab;
  logic [shp_pkg::SYNC_W-1:0] prev;

  // Lanes reset to their idle levels: clock low, the others high.
  // A clock lane reset high would show a false fall after reset.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= 4'hE;
      stab <= 4'hE;
      prev <= 4'hE;
    end else begin
      meta <= raw;
      stab <= meta;
      prev <= stab;
    end
  end

  assign o.lvl = stab;
  assign o.rise = stab & ~prev;
  assign o.fall = ~stab & prev;
endmodule : shp_sync

// *** src/shp_port.sv ***
// Serial host register port: command decode, register access, chain output
`timescale 1ns/100ps
module shp_port (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic jtag_select,
  input wire logic host_chip_sel_n,
  input wire logic host_sclk,
  input wire logic host_serial_in,
  output logic chain_serial_out,
  output logic port_active,
  output logic [shp_pkg::ADDR_W-1:0] reg_addr,
  output logic [shp_pkg::WORD_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [shp_pkg::WORD_W-1:0] reg_rdata
);
  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  shp_sync_if sif ();

  shp_sync u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .raw({jtag_select, host_serial_in, host_chip_sel_n, host_sclk}),
    .o(sif.src)
  );

  logic sclk_rise;
  logic sclk_fall;
  logic cs_n_s;
  logic host_serial_in_s;
  logic jsel_s;
  logic selected;
  assign sclk_rise = sif.rise[shp_pkg::LANE_SCLK];
  assign sclk_fall = sif.fall[shp_pkg::LANE_SCLK];
  assign cs_n_s = sif.lvl[shp_pkg::LANE_CSN];
  assign host_serial_in_s = sif.lvl[shp_pkg::LANE_HOST_SERIAL_IN];
  assign jsel_s = sif.lvl[shp_pkg::LANE_JSEL];
  assign selected = !jsel_s && !cs_n_s;

  // ----------------------------------------------------------------
  // Transaction state
  // ----------------------------------------------------------------
  shp_pkg::shp_state_t state, next_state;
  logic [shp_pkg::CNT_W-1:0] cnt, next_cnt;
  logic [shp_pkg::WORD_W-1:0] sh_in, next_sh_in;
  logic [shp_pkg::WORD_W-1:0] tx, next_tx;
  logic [shp_pkg::ADDR_W-1:0] ptr, next_ptr;
  logic rw, next_rw;
  logic step, next_step;
  logic drive, next_drive;
  logic first_fall, next_first_fall;
  logic next_port_active;
  logic [shp_pkg::ADDR_W-1:0] next_reg_addr;
  logic [shp_pkg::WORD_W-1:0] next_reg_wdata;
  logic next_reg_wr;
  logic next_reg_rd;
  logic [shp_pkg::WORD_W-1:0] word;

  assign word = {sh_in[shp_pkg::WORD_W-2:0], host_serial_in_s};

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sh_in = sh_in;
    next_tx = tx;
    next_ptr = ptr;
    next_rw = rw;
    next_step = step;
    next_drive = drive;
    next_first_fall = first_fall;
    next_port_active = !jsel_s;
    next_reg_addr = reg_addr;
    next_reg_wdata = reg_wdata;
    next_reg_wr = 1'b0;
    next_reg_rd = 1'b0;
    // Register data answers in the cycle of the read strobe
    if (reg_rd) begin
      next_tx = reg_rdata;
      next_first_fall = 1'b1;
    end
    if (!selected) begin
      // Chip select high aborts any partial word
      next_state = shp_pkg::SHP_IDLE;
      next_cnt = '0;
      next_drive = 1'b0;
      next_first_fall = 1'b0;
    end else begin
      unique case (state)
        shp_pkg::SHP_IDLE, shp_pkg::SHP_CMD: begin
          next_state = shp_pkg::SHP_CMD;
          if (sclk_rise) begin
            next_sh_in = word;
            next_cnt = shp_pkg::CNT_W'(cnt + 4'h1);
            if (cnt == shp_pkg::LAST_BIT) begin
              // Bits 14..13 are never looked at
              next_rw = word[shp_pkg::CMD_RW_BIT];
              next_step = word[shp_pkg::CMD_STEP_BIT];
              next_ptr = word[shp_pkg::CMD_ADDR_MSB:0];
              next_state = shp_pkg::SHP_DATA;
              if (word[shp_pkg::CMD_RW_BIT]) begin
                next_reg_addr = word[shp_pkg::CMD_ADDR_MSB:0];
                next_reg_rd = 1'b1;
                next_ptr = word[shp_pkg::CMD_ADDR_MSB:0] + shp_pkg::ADDR_ONE;
              end
            end
          end
        end
        shp_pkg::SHP_DATA: begin
          if (sclk_rise) begin
            next_sh_in = word;
            next_cnt = shp_pkg::CNT_W'(cnt + 4'h1);
            if (cnt == shp_pkg::LAST_BIT) begin
              if (!rw) begin
                // Every selected device in the chain stores this write
                next_reg_addr = ptr;
                next_reg_wdata = word;
                next_reg_wr = 1'b1;
                next_ptr = ptr + shp_pkg::ADDR_ONE;
              end else if (step) begin
                next_reg_addr = ptr;
                next_reg_rd = 1'b1;
                next_ptr = ptr + shp_pkg::ADDR_ONE;
              end
              if (!step) begin
                next_state = shp_pkg::SHP_CMD;
                next_drive = 1'b0;
              end
            end
          end else if (sclk_fall && rw) begin
            // First fall after a word boundary shows the MSB, later falls shift
            if (first_fall) begin
              next_drive = 1'b1;
              next_first_fall = 1'b0;
            end else begin
              next_tx = {tx[shp_pkg::WORD_W-2:0], 1'b0};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= shp_pkg::SHP_IDLE;
      cnt <= '0;
      sh_in <= shp_pkg::WORD_ZERO;
      tx <= shp_pkg::WORD_ZERO;
      ptr <= shp_pkg::ADDR_ZERO;
      rw <= 1'b0;
      step <= 1'b0;
      drive <= 1'b0;
      first_fall <= 1'b0;
      port_active <= 1'b0;
      reg_addr <= shp_pkg::ADDR_ZERO;
      reg_wdata <= shp_pkg::WORD_ZERO;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      sh_in <= next_sh_in;
      tx <= next_tx;
      ptr <= next_ptr;
      rw <= next_rw;
      step <= next_step;
      drive <= next_drive;
      first_fall <= next_first_fall;
      port_active <= next_port_active;
      reg_addr <= next_reg_addr;
      reg_wdata <= next_reg_wdata;
      reg_wr <= next_reg_wr;
      reg_rd <= next_reg_rd;
    end
  end

  // ----------------------------------------------------------------
  // Chain output
  // ----------------------------------------------------------------
  // Loop-through stays unclocked so chained devices see no added latency
  always_comb begin
    if (!port_active) begin
      chain_serial_out = 1'b0;
    end else if (drive) begin
      chain_serial_out = tx[shp_pkg::WORD_W-1];
    end else begin
      chain_serial_out = host_serial_in;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_JTAG_BLOCKS: assert property (jsel_s |=> !reg_wr && !reg_rd)
    else $error("access while JTAG selected");
  AST_ACTIVE_FOLLOWS_SELECT: assert property (port_active == !$past(jsel_s))
    else $error("port_active does not follow select");
  AST_WRITE_FLAG: assert property (reg_wr |-> !rw)
    else $error("write strobe in read transaction");
  AST_READ_FLAG: assert property (reg_rd |-> rw)
    else $error("read strobe in write transaction");
  AST_CMD_ADDR: assert property (
    (reg_rd && $past(state) != shp_pkg::SHP_DATA) |-> reg_addr == sh_in[11:0])
    else $error("read address not taken from command bits 11..0");
  AST_STEP_NEXT: assert property (
    (reg_wr || reg_rd) |-> ptr == reg_addr + shp_pkg::ADDR_ONE)
    else $error("address pointer not advanced by one");
  AST_WDATA_WORD: assert property (reg_wr |-> reg_wdata == sh_in)
    else $error("write data differs from shifted word");
  AST_MSB_ON_FALL: assert property ($rose(drive) |-> $past(sclk_fall))
    else $error("read data started off a falling edge");
  AST_LOOP_THROUGH: assert property (
    (port_active && !drive) |-> chain_serial_out == host_serial_in)
    else $error("chain output is not the serial input");
  AST_CS_HIGH_ENDS: assert property (cs_n_s |=> !drive ##1 !drive)
    else $error("data driven with chip select high");

  COV_WRITE: cover property (reg_wr && !step);
  COV_READ: cover property (reg_rd ##[1:200] $rose(drive));
  COV_STEP_WRITE: cover property (reg_wr && step ##[1:400] reg_wr);
  COV_STEP_READ: cover property (reg_rd && step ##[1:400] reg_rd);
endmodule : shp_port

// *** bench/shp_host.sv ***
// Host processor model that drives the serial register port
`timescale 1ns/100ps
module shp_host (
  input wire logic sys_clk,
  input wire logic chain_serial_out,
  output logic host_sclk,
  output logic host_chip_sel_n,
  output logic host_serial_in
);
  initial begin
    host_sclk = 1'b0;
    host_chip_sel_n = 1'b1;
    host_serial_in = 1'b1;
  end

  task automatic wait_fall(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wait_fall

  // Chip select low well ahead of the first clock rise
  task automatic open_frame();
    @(negedge sys_clk);
    host_chip_sel_n = 1'b0;
    wait_fall(4);
  endtask : open_frame

  // Shift n bits MSB first and take the output just before each rise;
  // a read bit stands from a few cycles after the fall until then, and
  // the port may move on soon after the rise
  task automatic bits(input logic [15:0] w, input int n,
                      output logic [15:0] r);
    r = 16'h0000;
    for (int i = 15; i > 15 - n; i--) begin
      host_sclk = 1'b0;
      host_serial_in = w[i];
      wait_fall(4);
      r[i] = chain_serial_out;
      host_sclk = 1'b1;
      wait_fall(4);
    end
  endtask : bits

  // Half an SCLK period low before each word keeps the write gap
  task automatic word(input logic [15:0] w, output logic [15:0] r);
    bits(w, 16, r);
  endtask : word

  // Clock parks low and the released data line must not look held
  task automatic close_frame();
    host_sclk = 1'b0;
    wait_fall(4);
    host_chip_sel_n = 1'b1;
    host_serial_in = ~host_serial_in;
    wait_fall(8);
  endtask : close_frame
endmodule : shp_host

// *** bench/shp_port_tb.sv ***
// Self-checking bench for the serial host register port
`timescale 1ns/100ps
module shp_port_tb;
  logic sys_clk, resetn, jtag_select, chain_serial_out, port_active;
  logic host_chip_sel_n, host_sclk, host_serial_in, reg_wr, reg_rd;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata, r;
  logic [15:0] mem [0:4095];
  int n_errors = 0;
  int total_checks = 0;

  shp_port shp_port_i (.sys_clk(sys_clk), .resetn(resetn),
    .jtag_select(jtag_select), .host_chip_sel_n(host_chip_sel_n),
    .host_sclk(host_sclk), .host_serial_in(host_serial_in),
    .chain_serial_out(chain_serial_out), .port_active(port_active),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(mem[reg_addr]));
  shp_host shp_host_i (.sys_clk(sys_clk), .chain_serial_out(chain_serial_out),
    .host_sclk(host_sclk), .host_chip_sel_n(host_chip_sel_n),
    .host_serial_in(host_serial_in));

  always @(posedge sys_clk) if (reg_wr === 1'b1) mem[reg_addr] <= reg_wdata;

  task automatic chk(input string nm, input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic complete_run();
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // Written words must come back unchanged on the chain output
  task automatic wr(input logic [15:0] cmd, input logic [15:0] d[$]);
    shp_host_i.open_frame();
    shp_host_i.word(cmd, r);
    chk("loop_cmd", r, cmd);
    foreach (d[k]) begin
      shp_host_i.word(d[k], r);
      chk("loop_data", r, d[k]);
    end
    shp_host_i.close_frame();
  endtask : wr

  // Only this device is selected while it answers a read
  task automatic rd(input logic [15:0] cmd, input logic [15:0] e[$]);
    shp_host_i.open_frame();
    shp_host_i.word(cmd, r);
    foreach (e[k]) begin
      shp_host_i.word(16'h0000, r);
      chk("read_data", r, e[k]);
    end
    shp_host_i.close_frame();
  endtask : rd

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    complete_run();
  end

  initial begin
    resetn = 1'b0;
    jtag_select = 1'b0;
    for (int i = 0; i < 4096; i++) mem[i] = {4'hA, i[11:0]};
    repeat (10) @(negedge sys_clk);
    chk("active_rst", {15'h0000, port_active}, 16'h0000);
    chk("out_rst", {15'h0000, chain_serial_out}, 16'h0000);
    resetn = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk("active", {15'h0000, port_active}, 16'h0001);
    // --------------------------------------------------------------
    // Writes, bursts, reads, aborted word, port handed to JTAG
    // --------------------------------------------------------------
    wr(16'h6123, '{16'hA5C3});
    chk("mem_123", mem[12'h123], 16'hA5C3);
    wr(16'h1FFE, '{16'h1111, 16'h2222, 16'h3333});
    chk("mem_FFE", mem[12'hFFE], 16'h1111);
    chk("mem_FFF", mem[12'hFFF], 16'h2222);
    chk("mem_000", mem[12'h000], 16'h3333);
    rd(16'h8123, '{16'hA5C3});
    rd(16'hE010, '{16'hA010});
    rd(16'h9FFF, '{16'h2222, 16'h3333});
    shp_host_i.open_frame();
    shp_host_i.word(16'h0040, r);
    shp_host_i.bits(16'hFFFF, 8, r);
    shp_host_i.close_frame();
    chk("mem_040", mem[12'h040], 16'hA040);
    jtag_select = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk("active_jtag", {15'h0000, port_active}, 16'h0000);
    // The output is parked low while the pins belong to JTAG
    shp_host_i.open_frame();
    shp_host_i.word(16'h0050, r);
    chk("out_jtag_cmd", r, 16'h0000);
    shp_host_i.word(16'h1234, r);
    chk("out_jtag_data", r, 16'h0000);
    shp_host_i.close_frame();
    chk("mem_050", mem[12'h050], 16'hA050);
    jtag_select = 1'b0;
    repeat (8) @(negedge sys_clk);
    wr(16'h0050, '{16'hBEEF});
    chk("mem_050b", mem[12'h050], 16'hBEEF);
    complete_run();
  end
endmodule : shp_port_tb
